// ---- core/csr_pkg.sv ----
// Constants for the core system register bank
package csr_pkg;
  localparam logic [7:0] CSR_ADDR_PAGE   = 8'hEA;
  localparam logic [7:0] CSR_ADDR_MODE   = 8'hEB;
  localparam logic [7:0] CSR_ADDR_USP_HI = 8'hEC;
  localparam logic [7:0] CSR_ADDR_USP_LO = 8'hED;
  localparam logic [7:0] CSR_ADDR_SSP_HI = 8'hEE;
  localparam logic [7:0] CSR_ADDR_SSP_LO = 8'hEF;
  localparam logic [7:0] CSR_MODE_RESET  = 8'hE0;
  localparam logic [7:0] CSR_ZERO8       = 8'h00;
  localparam logic [15:0] CSR_SP_RESET   = 16'h0000;
  localparam int CSR_PAGE_LSB   = 2;
  localparam int CSR_PAGE_MSB   = 7;
  localparam int CSR_MODE_SSP   = 7;
  localparam int CSR_MODE_USP   = 6;
  localparam int CSR_MODE_OSC_HALVING_SEL  = 5;
  localparam int CSR_MODE_PRS_L = 2;
  localparam int CSR_MODE_PRS_H = 4;
  localparam int CSR_MODE_BRQ   = 1;
  localparam int CSR_MODE_FLOAT = 0;
  // Linear space: 64 segments x 4 pages x 16 Kbyte
  localparam int CSR_SEG_BITS   = 6;
  localparam int CSR_PAGE_BITS  = 2;
  localparam int CSR_OFS_BITS   = 14;
  localparam int CSR_LIN_BITS   = 22;
  typedef enum logic [1:0] {
    CSR_STK_IDLE = 2'b00,
    CSR_STK_PUSH = 2'b01,
    CSR_STK_POP  = 2'b11
  } csr_stk_e;
endpackage

// ---- core/csr_core_sys_regs.sv ----
// System register bank: page select, operating mode and two stack pointers
`timescale 1ns/1ps
// Functional notes
// RL1 - Page pointer picks one of 64 16-register pages
// RL2 - Page number sits in bits 7..2
// RL3 - Bits 1..0 of page pointer read zero
// RL4 - Page holds until software writes new one
// RL5 - Interrupt code saves page pointer itself
// RL6 - Mode register resets to E0h
// RL7 - Bit 7 selects system stack location
// RL8 - Bit 6 selects user stack location
// RL9 - Bit 5 halves the oscillator clock
// RL10 - Bits 4..2 set core clock prescaler
// RL11 - Prescale factor is field value plus one
// RL12 - Bit 1 enables bus request input
// RL13 - Bit 0 floats external bus lines
// RL14 - Bus float leaves general I/O pins alone
// RL15 - Software floats bus when memory internal only
// RL16 - Pre-decrement on push, post-increment on pop
// RL17 - Pop leaves stack contents untouched
// RL18 - Interrupt pushes PC, flags, optional segment
// RL19 - Call pushes PC; segment call adds segment
// RL20 - Register-file stack uses low pointer byte
// RL21 - Software keeps internal stacks in groups 0-13
// RL22 - Software never stacks a pointer on itself
// RL23 - No stack overflow checking is done
// RL24 - Linear space: 64 segments of four 16K pages
module csr_core_sys_regs
  import csr_pkg::*;
#(
  parameter int PAGE_COUNT = 64,
  parameter int PAGE_REGS  = 16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        stk_push_i,
  input  wire logic        stk_pop_i,
  input  wire logic        stk_user_i,
  input  wire logic        stk_word_i,
  input  wire logic        bus_request_pin_i,
  input  wire logic        oscillator_input_i,
  input  wire logic [7:0]  io_pin_mask_i,
  output logic      [15:0] stk_addr_o,
  output logic             stk_addr_valid_o,
  output logic             stk_in_regfile_o,
  output logic      [5:0]  page_number_field_o,
  output logic             internal_core_clock_en_o,
  output logic             bus_request_o,
  output logic             external_bus_float_o,
  output logic      [7:0]  bus_line_float_o
);

  // Page map and linear space layout are fixed by the register-file decode
  initial begin
    if (PAGE_COUNT != 64 || PAGE_REGS != 16) begin
      $error("csr_core_sys_regs: only 64 pages of 16 registers supported");
    end
    if (PAGE_COUNT != (1 << (CSR_PAGE_MSB - CSR_PAGE_LSB + 1))) begin // [RL1]
      $error("csr_core_sys_regs: page count does not fit the page field");
    end
    if (CSR_LIN_BITS != CSR_SEG_BITS + CSR_PAGE_BITS + CSR_OFS_BITS) begin // [RL24]
      $error("csr_core_sys_regs: linear space split is inconsistent");
    end
  end

  // ==========================================================
  // Register storage
  logic [7:0]  page_sel;
  logic [7:0]  mode;
  logic [15:0] user_stack_location_sel;
  logic [15:0] system_stack_location_sel;
  // Registered op kind, kept so the checks can see what was done
  csr_stk_e    stk_op;

  wire wr_page  = reg_wr_i && (reg_addr_i == CSR_ADDR_PAGE);
  wire wr_mode  = reg_wr_i && (reg_addr_i == CSR_ADDR_MODE);
  wire wr_usphi = reg_wr_i && (reg_addr_i == CSR_ADDR_USP_HI);
  wire wr_usplo = reg_wr_i && (reg_addr_i == CSR_ADDR_USP_LO);
  wire wr_ssphi = reg_wr_i && (reg_addr_i == CSR_ADDR_SSP_HI);
  wire wr_ssplo = reg_wr_i && (reg_addr_i == CSR_ADDR_SSP_LO);

  wire       sys_internal = mode[CSR_MODE_SSP]; // [RL7]
  wire       usr_internal = mode[CSR_MODE_USP]; // [RL8]
  wire       sel_internal = stk_user_i ? usr_internal : sys_internal;
  // A word moves the pointer by two, a byte by one
  wire [1:0] step         = stk_word_i ? 2'h2 : 2'h1;

  // Register-file stacks move only the low byte; high byte is left alone
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic internal,
                                          input logic dec, input logic [1:0] st);
    logic [15:0] r;
    r = dec ? sp - {14'h0000, st} : sp + {14'h0000, st};
    if (internal) begin
      r = {sp[15:8], r[7:0]}; // [RL20]
    end
    return r;
  endfunction

  // Wrap silently: no bound checking on either stack [RL23]
  wire [15:0] next_usp_push = sp_step(user_stack_location_sel, usr_internal, 1'b1, step);
  wire [15:0] next_ssp_push = sp_step(system_stack_location_sel, sys_internal, 1'b1, step);
  wire [15:0] next_usp_pop  = sp_step(user_stack_location_sel, usr_internal, 1'b0, step);
  wire [15:0] next_ssp_pop  = sp_step(system_stack_location_sel, sys_internal, 1'b0, step);

  // Push and pop together is treated as no operation
  wire push_go = stk_push_i && !stk_pop_i;
  wire pop_go  = stk_pop_i && !stk_push_i;

  // Register-bus writes win over stack updates in the same cycle
  wire [15:0] next_usp =
    wr_usphi ? {reg_wdata_i, user_stack_location_sel[7:0]} :
    wr_usplo ? {user_stack_location_sel[15:8], reg_wdata_i} :
    (push_go && stk_user_i)  ? next_usp_push :
    (pop_go && stk_user_i)   ? next_usp_pop  : user_stack_location_sel;
  wire [15:0] next_ssp =
    wr_ssphi ? {reg_wdata_i, system_stack_location_sel[7:0]} :
    wr_ssplo ? {system_stack_location_sel[15:8], reg_wdata_i} :
    (push_go && !stk_user_i) ? next_ssp_push :
    (pop_go && !stk_user_i)  ? next_ssp_pop  : system_stack_location_sel;

  // Push presents the decremented address; pop the current one [RL16]
  // Pops only read, so stack memory keeps its contents [RL17]
  wire [15:0] cur_sp     = stk_user_i ? user_stack_location_sel : system_stack_location_sel;
  wire [15:0] push_sp    = stk_user_i ? next_usp_push : next_ssp_push;
  wire [15:0] next_saddr = push_go ? push_sp : cur_sp;
  wire [15:0] next_saddr_m = sel_internal ? {CSR_ZERO8, next_saddr[7:0]} : next_saddr; // [RL20]

  // ==========================================================
  // Register write path
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      page_sel <= CSR_ZERO8;
      mode     <= CSR_MODE_RESET; // [RL6]
      user_stack_location_sel      <= CSR_SP_RESET;
      system_stack_location_sel      <= CSR_SP_RESET;
    end else begin
      if (wr_page) begin
        // Low bits dropped at the write, so no read path has to mask them
        page_sel <= {reg_wdata_i[CSR_PAGE_MSB:CSR_PAGE_LSB], 2'b00}; // [RL2] [RL3] [RL4]
      end
      if (wr_mode) begin
        mode <= reg_wdata_i;
      end
      user_stack_location_sel <= next_usp; // [RL16]
      system_stack_location_sel <= next_ssp; // [RL16]
    end
  end

  // ==========================================================
  // Read path
  // Unmapped addresses read zero so a stray read leaks no state
  wire [7:0] next_rdata =
    (reg_addr_i == CSR_ADDR_PAGE)   ? page_sel  :
    (reg_addr_i == CSR_ADDR_MODE)   ? mode      :
    (reg_addr_i == CSR_ADDR_USP_HI) ? user_stack_location_sel[15:8] :
    (reg_addr_i == CSR_ADDR_USP_LO) ? user_stack_location_sel[7:0]  :
    (reg_addr_i == CSR_ADDR_SSP_HI) ? system_stack_location_sel[15:8] :
    (reg_addr_i == CSR_ADDR_SSP_LO) ? system_stack_location_sel[7:0]  : CSR_ZERO8;

  // ==========================================================
  // Clock divider: optional halving then prescale by field + 1
  logic       half_tgl;
  logic [2:0] prs_cnt;
  wire  [2:0] prs_field = mode[CSR_MODE_PRS_H:CSR_MODE_PRS_L]; // [RL10]
  // Oscillator input qualifies each tick; it is taken as synchronous
  wire        osc_tick  = oscillator_input_i && (!mode[CSR_MODE_OSC_HALVING_SEL] || half_tgl); // [RL9]
  // Compare with >= so a smaller field written mid-count wraps at once
  wire        prs_wrap  = (prs_cnt >= prs_field); // [RL11]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      half_tgl <= 1'b0;
      prs_cnt  <= 3'h0;
    end else begin
      // Halving toggle follows every input tick, keeping phase with it
      if (oscillator_input_i) begin
        half_tgl <= ~half_tgl;
      end
      if (osc_tick) begin
        prs_cnt <= prs_wrap ? 3'h0 : prs_cnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // Output flops
  // Reset shows the stacks internal, matching the mode reset value
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o              <= CSR_ZERO8;
      stk_addr_o               <= CSR_SP_RESET;
      stk_addr_valid_o         <= 1'b0;
      stk_in_regfile_o         <= 1'b1;
      stk_op                   <= CSR_STK_IDLE;
      page_number_field_o      <= 6'h00;
      internal_core_clock_en_o <= 1'b0;
      bus_request_o            <= 1'b0;
      external_bus_float_o     <= 1'b0;
      bus_line_float_o         <= CSR_ZERO8;
    end else begin
      reg_rdata_o              <= next_rdata;
      stk_addr_o               <= next_saddr_m;
      stk_addr_valid_o         <= push_go || pop_go;
      stk_in_regfile_o         <= sel_internal;
      stk_op                   <= push_go ? CSR_STK_PUSH : pop_go ? CSR_STK_POP : CSR_STK_IDLE;
      page_number_field_o      <= page_sel[CSR_PAGE_MSB:CSR_PAGE_LSB]; // [RL1]
      internal_core_clock_en_o <= osc_tick && prs_wrap; // [RL10]
      bus_request_o            <= bus_request_pin_i && mode[CSR_MODE_BRQ]; // [RL12]
      external_bus_float_o     <= mode[CSR_MODE_FLOAT]; // [RL13]
      // Pins set up as general I/O never float [RL14]
      bus_line_float_o         <= mode[CSR_MODE_FLOAT] ? ~io_pin_mask_i : CSR_ZERO8;
    end
  end

  // ==========================================================
  // Checks
  page_low_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL3]
    page_sel[1:0] == 2'b00) else $error("page pointer low bits not zero");

  page_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL4]
    !wr_page |=> page_sel == $past(page_sel)) else $error("page pointer changed");

  page_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL2]
    wr_page |=> ##1 page_number_field_o == $past(reg_wdata_i[7:2], 2))
    else $error("page number not shown");

  mode_reset_a: assert property (@(posedge ref_clk_i) // [RL6]
    !rst_n_i |=> mode == CSR_MODE_RESET) else $error("mode reset value wrong");

  push_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    (push_go && !stk_user_i && !sys_internal && !wr_ssphi && !wr_ssplo)
      |=> system_stack_location_sel == $past(system_stack_location_sel) - ($past(stk_word_i) ? 16'h2 : 16'h1) && stk_addr_o == system_stack_location_sel)
    else $error("push did not pre-decrement");

  pop_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    (pop_go && stk_user_i && !usr_internal && !wr_usphi && !wr_usplo)
      |=> user_stack_location_sel == $past(user_stack_location_sel) + ($past(stk_word_i) ? 16'h2 : 16'h1) && stk_addr_o == $past(user_stack_location_sel))
    else $error("pop did not post-increment");

  int_hi_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL20]
    (sys_internal && !wr_ssphi) |=> system_stack_location_sel[15:8] == $past(system_stack_location_sel[15:8]))
    else $error("internal stack touched high byte");

  brq_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL12]
    !mode[CSR_MODE_BRQ] |=> !bus_request_o) else $error("bus request not gated");

  float_io_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL14]
    1'b1 |=> (bus_line_float_o & $past(io_pin_mask_i)) == 8'h00)
    else $error("I/O pin floated");

  prs_none_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL11]
    (prs_field == 3'h0 && !mode[CSR_MODE_OSC_HALVING_SEL] && oscillator_input_i && !wr_mode)
      |=> internal_core_clock_en_o) else $error("prescale 1 missed tick");

  // ==========================================================
  // Stack checks
  // Both strobes together are refused rather than guessed at
  both_refused_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    (stk_push_i && stk_pop_i && !wr_ssphi && !wr_ssplo)
      |=> !stk_addr_valid_o && system_stack_location_sel == $past(system_stack_location_sel))
    else $error("push and pop together not refused");

  op_kind_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    stk_addr_valid_o == (stk_op != CSR_STK_IDLE))
    else $error("stack op kind and valid disagree");

  sys_pop_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    (pop_go && !stk_user_i && !sys_internal && !wr_ssphi && !wr_ssplo)
      |=> system_stack_location_sel == $past(system_stack_location_sel) + ($past(stk_word_i) ? 16'h2 : 16'h1) && stk_addr_o == $past(system_stack_location_sel))
    else $error("system pop did not post-increment");

  usr_push_dec_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL16]
    (push_go && stk_user_i && !usr_internal && !wr_usphi && !wr_usplo)
      |=> user_stack_location_sel == $past(user_stack_location_sel) - ($past(stk_word_i) ? 16'h2 : 16'h1) && stk_addr_o == user_stack_location_sel)
    else $error("user push did not pre-decrement");

  int_addr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL20]
    ((push_go || pop_go) && sel_internal) |=> stk_addr_o[15:8] == 8'h00)
    else $error("register-file stack address has a high byte");

  int_low_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL20] [RL23]
    (push_go && !stk_user_i && sys_internal && !wr_ssphi && !wr_ssplo)
      |=> system_stack_location_sel[7:0] == $past(system_stack_location_sel[7:0]) - ($past(stk_word_i) ? 8'h02 : 8'h01))
    else $error("register-file push did not wrap in low byte");

  regfile_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL7] [RL8]
    1'b1 |=> stk_in_regfile_o ==
      $past(stk_user_i ? mode[CSR_MODE_USP] : mode[CSR_MODE_SSP]))
    else $error("stack location flag wrong");

  // ==========================================================
  // Mode and page checks
  // Mode only moves on a bus write; nothing in hardware touches it
  mode_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL6]
    !wr_mode |=> mode == $past(mode))
    else $error("mode register changed without a write");

  mode_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL7] [RL9]
    wr_mode |=> mode == $past(reg_wdata_i))
    else $error("mode register write lost");

  float_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL13]
    !mode[CSR_MODE_FLOAT] |=> !external_bus_float_o && bus_line_float_o == 8'h00)
    else $error("bus floated with the bit clear");

  float_on_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL13]
    mode[CSR_MODE_FLOAT] |=> external_bus_float_o &&
      bus_line_float_o == ~$past(io_pin_mask_i))
    else $error("bus not floated with the bit set");

  brq_pass_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL12]
    (mode[CSR_MODE_BRQ] && bus_request_pin_i) |=> bus_request_o)
    else $error("enabled bus request not passed");

  page_rd_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL3]
    (reg_addr_i == CSR_ADDR_PAGE) |=> reg_rdata_o[1:0] == 2'b00)
    else $error("page pointer read low bits not zero");

  page_field_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL1]
    1'b1 |=> page_number_field_o == $past(page_sel[CSR_PAGE_MSB:CSR_PAGE_LSB]))
    else $error("page number output stale");

  // ==========================================================
  // Clock checks
  // A pulse clears the count, so a field above zero forces a gap
  half_skip_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL9]
    (mode[CSR_MODE_OSC_HALVING_SEL] && !half_tgl) |=> !internal_core_clock_en_o)
    else $error("halved clock ticked on a skipped input");

  prs_gap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL11]
    (internal_core_clock_en_o && prs_field != 3'h0) |=> !internal_core_clock_en_o)
    else $error("prescaled clock pulsed twice in a row");

  osc_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL10]
    !oscillator_input_i |=> !internal_core_clock_en_o)
    else $error("core clock pulsed without an input tick");

endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the core system register bank
`timescale 1ns/1ps
module tb_top;
  import csr_pkg::*;
  logic        ref_clk_i          = 1'b0;
  logic        rst_n_i            = 1'b0;
  logic [7:0]  reg_addr_i         = 8'h00;
  logic        reg_wr_i           = 1'b0;
  logic [7:0]  reg_wdata_i        = 8'h00;
  logic        stk_push_i         = 1'b0;
  logic        stk_pop_i          = 1'b0;
  logic        stk_user_i         = 1'b0;
  logic        stk_word_i         = 1'b0;
  logic        bus_request_pin_i  = 1'b0;
  logic        oscillator_input_i = 1'b0;
  logic [7:0]  io_pin_mask_i      = 8'h00;
  logic [7:0]  reg_rdata_o;
  logic [15:0] stk_addr_o;
  logic        stk_addr_valid_o;
  logic        stk_in_regfile_o;
  logic [5:0]  page_number_field_o;
  logic        internal_core_clock_en_o;
  logic        bus_request_o;
  logic        external_bus_float_o;
  logic [7:0]  bus_line_float_o;
  int          err_total;
  int          tests_run;
  int          pg;
  int          md;
  logic [15:0] sp [2];
  logic [7:0]  d_m [4] = '{8'h00, 8'hC0, 8'h80, 8'h40};
  csr_core_sys_regs dut_u (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .stk_push_i, .stk_pop_i, .stk_user_i, .stk_word_i, .bus_request_pin_i,
    .oscillator_input_i, .io_pin_mask_i, .stk_addr_o, .stk_addr_valid_o, .stk_in_regfile_o,
    .page_number_field_o, .internal_core_clock_en_o, .bus_request_o, .external_bus_float_o,
    .bus_line_float_o);
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // Checking and closing
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Register and stack drivers, model updated alongside
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    case (a)
      CSR_ADDR_PAGE:   pg = d & 8'hFC;
      CSR_ADDR_MODE:   md = d;
      CSR_ADDR_USP_HI: sp[1][15:8] = d;
      CSR_ADDR_USP_LO: sp[1][7:0] = d;
      CSR_ADDR_SSP_HI: sp[0][15:8] = d;
      CSR_ADDR_SSP_LO: sp[0][7:0] = d;
      default: ;
    endcase
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    case (a)
      CSR_ADDR_PAGE:   e = 8'(pg);
      CSR_ADDR_MODE:   e = 8'(md);
      CSR_ADDR_USP_HI: e = sp[1][15:8];
      CSR_ADDR_USP_LO: e = sp[1][7:0];
      CSR_ADDR_SSP_HI: e = sp[0][15:8];
      CSR_ADDR_SSP_LO: e = sp[0][7:0];
      default:         e = 8'h00;
    endcase
    @(negedge ref_clk_i);
    reg_addr_i = a;
    @(negedge ref_clk_i);
    chk("reg_rdata", reg_rdata_o, e);
  endtask
  task automatic sop(bit push, bit usr, bit word);
    logic [15:0] p;
    logic [15:0] ea;
    bit          in;
    p = sp[usr];
    in = md[7 - usr];
    // Internal stacks only step the low byte; the high byte is left alone
    if (push) p = in ? {p[15:8], 8'(p[7:0] - (word ? 2 : 1))} : 16'(p - (word ? 2 : 1));
    ea = in ? {8'h00, p[7:0]} : p;
    if (!push) p = in ? {p[15:8], 8'(p[7:0] + (word ? 2 : 1))} : 16'(p + (word ? 2 : 1));
    sp[usr] = p;
    @(negedge ref_clk_i);
    stk_user_i = usr;
    stk_word_i = word;
    stk_push_i = push;
    stk_pop_i = !push;
    @(negedge ref_clk_i);
    stk_push_i = 1'b0;
    stk_pop_i = 1'b0;
    chk("stk_valid", stk_addr_valid_o, 16'h1);
    chk("stk_addr", stk_addr_o, ea);
    chk("stk_regfile", stk_in_regfile_o, 16'(in));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int d;
    int cnt;
    int e;
    pg = 0;
    md = 8'hE0;
    sp[0] = CSR_SP_RESET;
    sp[1] = CSR_SP_RESET;
    void'($urandom(32'h8f04));
    repeat (6) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int a = 8'hE9; a <= 8'hF0; a++) rd(8'(a));
    chk("page_field", page_number_field_o, 16'h0);
    $display("test reset_values done");
    repeat (8) begin
      d = $urandom;
      wr(CSR_ADDR_PAGE, 8'(d));
      rd(CSR_ADDR_MODE);
      rd(CSR_ADDR_PAGE);
      chk("page_field", page_number_field_o, 16'(d[7:2]));
    end
    $display("test page_select done");
    repeat (8) begin
      d = $urandom;
      io_pin_mask_i = 8'($urandom);
      bus_request_pin_i = 1'($urandom);
      wr(CSR_ADDR_MODE, 8'(d));
      rd(CSR_ADDR_MODE);
      chk("bus_req", bus_request_o, 16'(bus_request_pin_i & d[1]));
      chk("bus_float", external_bus_float_o, 16'(d[0]));
      chk("line_float", bus_line_float_o, d[0] ? 16'(~io_pin_mask_i) : 16'h0);
    end
    $display("test mode_outputs done");
    foreach (d_m[i]) begin
      wr(CSR_ADDR_MODE, d_m[i]);
      wr(CSR_ADDR_SSP_HI, 8'h01);
      wr(CSR_ADDR_SSP_LO, 8'hC0);
      repeat (8) sop(1'($urandom), 1'($urandom), 1'($urandom));
      @(negedge ref_clk_i);
      stk_push_i = 1'b1;
      stk_pop_i = 1'b1;
      @(negedge ref_clk_i);
      stk_push_i = 1'b0;
      stk_pop_i = 1'b0;
      chk("stk_both", stk_addr_valid_o, 16'h0);
      for (int a = 8'hEC; a <= 8'hEF; a++) rd(8'(a));
    end
    $display("test stack_ops done");
    for (int q = 0; q < 16; q++) begin
      wr(CSR_ADDR_MODE, 8'(q << 2));
      cnt = 0;
      repeat (96) begin
        @(negedge ref_clk_i);
        cnt += internal_core_clock_en_o;
        oscillator_input_i = ~oscillator_input_i;
      end
      e = 48 / ((q[3] ? 2 : 1) * (q[2:0] + 1));
      // One pulse of slack, the divider phase at the mode write is free
      chk("core_clk_en", 16'(cnt >= e - 1 && cnt <= e + 1), 16'h1);
    end
    $display("test clock_prescale done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    give_verdict();
  end
endmodule
